// >>> rtl/csop_map.svh
`ifndef CSOP_MAP_SVH
`define CSOP_MAP_SVH
`define CSOP_VAL_W 8
`define CSOP_NIB_W 4
`define CSOP_LO_LSB 0
`define CSOP_HI_LSB 4
`define CSOP_VAL_RST 8'h00
`define CSOP_UPSEL_RST 1'b1
`define CSOP_NUM_CH 16
`define CSOP_NUM_DRV 4
`endif

// >>> rtl/csop_pkg.sv
package csop_pkg;
    typedef logic [7:0] csop_val_t;
    typedef enum logic [1:0] {
        CSOP_IDLE,
        CSOP_ACTIVE,
        CSOP_HOLD
    } csop_state_t;
endpackage

// >>> rtl/csop_sel_if.sv
`timescale 1ns/10ps
interface csop_sel_if #(parameter int CH_W = 4);
    logic [CH_W-1:0] ch;
    logic [7:0] val;
    modport store (input ch, output val);
    modport user (output ch, input val);
endinterface

// >>> rtl/csop_store.sv
`timescale 1ns/10ps
`include "csop_map.svh"
module csop_store #(
    parameter int NUM_CH = `CSOP_NUM_CH,
    parameter int CH_W = 4
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // write and read port
    input wire logic wr_en,
    input wire logic [CH_W-1:0] wr_ch,
    input wire logic [`CSOP_VAL_W-1:0] wr_val,
    input wire logic [CH_W-1:0] rd_ch,
    output logic [`CSOP_VAL_W-1:0] rd_val,
    // sweep lookup
    csop_sel_if.store sel
);
    logic [`CSOP_VAL_W-1:0] mem_r [NUM_CH];
    logic [`CSOP_VAL_W-1:0] mem_nxt [NUM_CH];

    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            mem_nxt[i] = mem_r[i];
        end
        if (wr_en) begin
            mem_nxt[wr_ch] = wr_val;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < NUM_CH; i++) begin
                mem_r[i] <= `CSOP_VAL_RST;
            end
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                mem_r[i] <= mem_nxt[i];
            end
        end
    end

    assign rd_val = mem_r[rd_ch];
    assign sel.val = mem_r[sel.ch];
endmodule

// >>> rtl/csop_port.sv
`timescale 1ns/10ps
`include "csop_map.svh"
module csop_port #(
    parameter int NUM_CH = `CSOP_NUM_CH,
    parameter int CH_W = 4
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // software access
    input wire logic wr_en,
    input wire logic [CH_W-1:0] wr_ch,
    input wire logic [`CSOP_VAL_W-1:0] channel_output_value,
    input wire logic [CH_W-1:0] rd_ch,
    output logic [`CSOP_VAL_W-1:0] rd_val,
    input wire logic upper_line_select_wr,
    input wire logic upper_line_select_in,
    output logic upper_line_select,
    // sweep engine events
    input wire logic sweep_start,
    input wire logic [CH_W-1:0] sweep_ch,
    input wire logic sweep_hold,
    input wire logic drive_valid,
    input wire logic [1:0] drive_port,
    // connector and sweep state
    output logic [`CSOP_VAL_W-1:0] aux_output_connector,
    output logic [1:0] port_state
);
    csop_sel_if #(.CH_W(CH_W)) sel ();

    csop_store #(.NUM_CH(NUM_CH), .CH_W(CH_W)) u_store (
        .core_clk(core_clk),
        .reset(reset),
        .wr_en(wr_en),
        .wr_ch(wr_ch),
        .wr_val(channel_output_value),
        .rd_ch(rd_ch),
        .rd_val(rd_val),
        .sel(sel)
    );

    csop_pkg::csop_state_t st_r, st_nxt;
    logic [CH_W-1:0] ch_r, ch_nxt;
    logic upsel_r, upsel_nxt;
    logic [`CSOP_VAL_W-1:0] out_r, out_nxt;
    // channel bits last shown, kept apart so monitoring cannot overwrite them
    logic [`CSOP_VAL_W-1:0] held_r, held_nxt;

    function automatic logic [`CSOP_NIB_W-1:0] onehot4(input logic v, input logic [1:0] p);
        onehot4 = v ? (4'h1 << p) : 4'h0;
    endfunction

    assign sel.ch = ch_r;

    always_comb begin
        st_nxt = st_r;
        ch_nxt = ch_r;
        upsel_nxt = upsel_r;
        if (upper_line_select_wr) begin
            upsel_nxt = upper_line_select_in;
        end
        unique case (st_r)
            csop_pkg::CSOP_IDLE: begin
                if (sweep_start) begin
                    st_nxt = csop_pkg::CSOP_ACTIVE;
                    ch_nxt = sweep_ch;
                end
            end
            csop_pkg::CSOP_ACTIVE: begin
                if (sweep_hold) begin
                    st_nxt = csop_pkg::CSOP_HOLD;
                end else if (sweep_start) begin
                    ch_nxt = sweep_ch;
                end
            end
            csop_pkg::CSOP_HOLD: begin
                if (sweep_start) begin
                    st_nxt = csop_pkg::CSOP_ACTIVE;
                    ch_nxt = sweep_ch;
                end
            end
            default: st_nxt = csop_pkg::CSOP_IDLE;
        endcase
    end

    always_comb begin
        out_nxt = out_r;
        held_nxt = held_r;
        if (st_r == csop_pkg::CSOP_ACTIVE) begin
            out_nxt = sel.val;
            held_nxt = sel.val;
            if (!upsel_r) begin
                out_nxt[`CSOP_HI_LSB +: `CSOP_NIB_W] = onehot4(drive_valid, drive_port);
            end
        end else if (st_r == csop_pkg::CSOP_HOLD) begin
            // held channel bits return if the select is switched on in hold
            out_nxt = held_r;
            if (!upsel_r) begin
                out_nxt[`CSOP_HI_LSB +: `CSOP_NIB_W] = onehot4(drive_valid, drive_port);
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            st_r <= csop_pkg::CSOP_IDLE;
            ch_r <= '0;
            upsel_r <= `CSOP_UPSEL_RST;
            out_r <= `CSOP_VAL_RST;
            held_r <= `CSOP_VAL_RST;
        end else begin
            st_r <= st_nxt;
            ch_r <= ch_nxt;
            upsel_r <= upsel_nxt;
            out_r <= out_nxt;
            held_r <= held_nxt;
        end
    end

    assign aux_output_connector = out_r;
    assign upper_line_select = upsel_r;
    assign port_state = st_r;

    chk_reset_clear: assert property (@(posedge core_clk) $fell(reset) |-> out_r == 8'h00)
        else $error("lines not clear after reset");
    chk_reset_upsel: assert property (@(posedge core_clk)
        $fell(reset) |-> upsel_r && st_r == csop_pkg::CSOP_IDLE)
        else $error("select not on after reset");
    chk_follow_channel: assert property (@(posedge core_clk) disable iff (reset)
        st_r == csop_pkg::CSOP_ACTIVE && upsel_r |=> out_r == $past(sel.val))
        else $error("lines do not follow sweeping channel");
    chk_hold_keep: assert property (@(posedge core_clk) disable iff (reset)
        st_r == csop_pkg::CSOP_HOLD && upsel_r && $past(upsel_r) |=> $stable(out_r))
        else $error("lines changed in hold");
    chk_idle_quiet: assert property (@(posedge core_clk) disable iff (reset)
        st_r == csop_pkg::CSOP_IDLE |=> $stable(out_r))
        else $error("lines moved before a sweep");
    chk_start_enter: assert property (@(posedge core_clk) disable iff (reset)
        st_r == csop_pkg::CSOP_IDLE && sweep_start |=> st_r == csop_pkg::CSOP_ACTIVE && ch_r == $past(sweep_ch))
        else $error("sweep start not taken");
    chk_change_follow: assert property (@(posedge core_clk) disable iff (reset)
        st_r == csop_pkg::CSOP_ACTIVE && sweep_start && !sweep_hold
        |=> st_r == csop_pkg::CSOP_ACTIVE && ch_r == $past(sweep_ch))
        else $error("channel change not taken");
    chk_hold_enter: assert property (@(posedge core_clk) disable iff (reset)
        st_r == csop_pkg::CSOP_ACTIVE && sweep_hold |=> st_r == csop_pkg::CSOP_HOLD)
        else $error("hold not entered");
    chk_mon_onehot: assert property (@(posedge core_clk) disable iff (reset)
        st_r != csop_pkg::CSOP_IDLE && !upsel_r
        |=> out_r[7:4] == ($past(drive_valid) ? (4'h1 << $past(drive_port)) : 4'h0))
        else $error("drive monitor not one-hot");
    chk_mon_low: assert property (@(posedge core_clk) disable iff (reset)
        !upsel_r && !drive_valid && st_r != csop_pkg::CSOP_IDLE |=> out_r[7:4] == 4'h0)
        else $error("drive monitor lines not low");
    chk_upsel_load: assert property (@(posedge core_clk) disable iff (reset)
        upper_line_select_wr |=> upsel_r == $past(upper_line_select_in))
        else $error("select setting not loaded");
    chk_write_only: assert property (@(posedge core_clk) disable iff (reset)
        wr_en && !sweep_start && !sweep_hold |=> st_r == $past(st_r) && ch_r == $past(ch_r))
        else $error("write disturbed sweep state");
    chk_write_store: assert property (@(posedge core_clk) disable iff (reset)
        wr_en && rd_ch == wr_ch ##1 rd_ch == $past(rd_ch) |-> rd_val == $past(channel_output_value))
        else $error("written value not stored");
    cov_start: cover property (@(posedge core_clk) disable iff (reset) st_r == csop_pkg::CSOP_IDLE && sweep_start);
    cov_change: cover property (@(posedge core_clk) disable iff (reset)
        st_r == csop_pkg::CSOP_ACTIVE && sweep_start && sweep_ch != ch_r);
    cov_hold: cover property (@(posedge core_clk) disable iff (reset) st_r == csop_pkg::CSOP_HOLD);
    cov_monitor: cover property (@(posedge core_clk) disable iff (reset) !upsel_r && drive_valid);
    cov_reselect_hold: cover property (@(posedge core_clk) disable iff (reset)
        st_r == csop_pkg::CSOP_HOLD && upper_line_select_wr);
endmodule

// >>> dv/csop_equip_model.sv
`timescale 1ns/10ps
module csop_equip_model (
    // clock
    input wire logic core_clk,
    // connector lines in, latched sample out
    input wire logic [7:0] lines,
    output logic [7:0] seen
);
    // external gear latches the lines on each rising edge
    always_ff @(posedge core_clk) begin
        seen <= lines;
    end
endmodule

// >>> dv/tb_channel_state_output_port.sv
`timescale 1ns/10ps
module tb_channel_state_output_port;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic wr_en = 1'b0;
    logic [3:0] wr_ch = 4'h0;
    logic [3:0] rd_ch = 4'h0;
    logic [3:0] sw_ch = 4'h0;
    logic [7:0] wr_val = 8'h00;
    logic [7:0] rd_val, lines, seen;
    logic uls_wr = 1'b0;
    logic uls_in = 1'b1;
    logic uls, start = 1'b0, hold = 1'b0, drive_valid = 1'b0;
    logic [1:0] drive_port = 2'h0;
    logic [1:0] state;
    int failures = 0;
    int compares = 0;
    int cycles = 0;
    int mem[16];
    int cur = 0;
    int st = 0;
    int frz = 0;
    bit upsel = 1'b1;
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    csop_port dut (.core_clk(core_clk), .reset(reset), .wr_en(wr_en), .wr_ch(wr_ch),
        .channel_output_value(wr_val), .rd_ch(rd_ch), .rd_val(rd_val), .upper_line_select_wr(uls_wr),
        .upper_line_select_in(uls_in), .upper_line_select(uls), .sweep_start(start), .sweep_ch(sw_ch),
        .sweep_hold(hold), .drive_valid(drive_valid), .drive_port(drive_port),
        .aux_output_connector(lines), .port_state(state));
    csop_equip_model u_equip (.core_clk(core_clk), .lines(lines), .seen(seen));
    function automatic logic [7:0] exp_lines();
        logic [7:0] v;
        v = (st == 2) ? 8'(frz) : (st == 1) ? 8'(mem[cur]) : 8'h00;
        if (!upsel) v[7:4] = (st != 0 && drive_valid) ? 4'(1 << drive_port) : 4'h0;
        return v;
    endfunction
    task automatic give_verdict();
        if (failures == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %0t: value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_state(input logic [1:0] got, input logic [1:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %0t: state %h expected %h", $time, got, exp);
        end
    endtask
    task automatic settle();
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        chk_val(seen, exp_lines());
        chk_state(state, 2'(st));
        chk_state({1'b0, uls}, {1'b0, upsel});
    endtask
    task automatic rd_all();
        for (int i = 0; i < 16; i++) begin
            @(posedge core_clk);
            rd_ch <= 4'(i);
            @(negedge core_clk);
            chk_val(rd_val, 8'(mem[i]));
        end
    endtask
    task automatic wr(input int ch, input int v);
        @(posedge core_clk);
        wr_en <= 1'b1;
        wr_ch <= 4'(ch);
        wr_val <= 8'(v);
        mem[ch] = v;
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask
    task automatic go(input int ch);
        @(posedge core_clk);
        start <= 1'b1;
        sw_ch <= 4'(ch);
        drive_valid <= 1'b1;
        drive_port <= 2'($urandom);
        @(posedge core_clk);
        start <= 1'b0;
        cur = ch;
        st = 1;
    endtask
    task automatic pulse(input int kind, input bit on);
        @(posedge core_clk);
        if (kind == 0) hold <= 1'b1;
        else uls_wr <= 1'b1;
        uls_in <= on;
        @(posedge core_clk);
        hold <= 1'b0;
        uls_wr <= 1'b0;
        if (kind == 0) frz = mem[cur];
        if (kind == 0) st = 2;
        else upsel = on;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            give_verdict();
        end
    end
    initial begin
        void'($urandom(5));
        repeat (20) @(posedge core_clk);
        reset <= 1'b0;
        settle();
        rd_all();
        for (int i = 0; i < 16; i++) begin
            wr(i, (i < 3) ? i + 1 : (i == 3) ? 255 : (i == 4) ? 0 : $urandom_range(255));
        end
        settle();
        rd_all();
        for (int i = 0; i < 16; i++) begin
            go(i);
            settle();
        end
        go(2);
        wr(5, 8'h3c);
        settle();
        wr(2, 8'ha5);
        settle();
        pulse(0, 1'b1);
        wr(2, 8'h5a);
        settle();
        pulse(1, 1'b0);
        for (int p = 0; p < 4; p++) begin
            @(posedge core_clk);
            drive_port <= 2'(p);
            settle();
        end
        @(posedge core_clk);
        drive_valid <= 1'b0;
        settle();
        pulse(1, 1'b1);
        settle();
        pulse(1, 1'b0);
        go(3);
        settle();
        pulse(1, 1'b1);
        settle();
        @(posedge core_clk);
        reset <= 1'b1;
        @(posedge core_clk);
        reset <= 1'b0;
        mem = '{default: 0};
        st = 0;
        upsel = 1'b1;
        settle();
        rd_all();
        give_verdict();
    end
endmodule
